// ===== rtl/spi_boot_loader_engine.sv
// Serial boot loader engine: slave and master boot into internal memory
`timescale 1ns/1ps
`default_nettype none
`include "spi_boot_regs.svh"

module spi_boot_loader_engine
  import spi_boot_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Boot strap pins
  input wire logic [1:0] boot_config_pins,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Serial clock pin, two-way
  input wire logic serialClockIn,
  output logic serialClockOut,
  output logic serialClockOeN,
  // Select and data pins
  input wire logic deviceSelectN,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOeN,
  output logic generalFlagZeroN,
  // Internal memory write port
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [31:0] memData,
  // Status
  output logic bootDone,
  output logic irq
);

  // Registered state and its next value
  engine_state_t st_ff;
  engine_state_t nxt_st;

  // Reverse the bits of a byte
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // Last bit index of one source word
  function automatic logic [4:0] lastBit(input logic [1:0] w);
    logic [4:0] r;
    case (w)
      `SRC_W8: r = 5'h07;
      `SRC_W16: r = 5'h0f;
      default: r = 5'h1f;
    endcase
    return r;
  endfunction

  // Last source word index inside one shifter word
  function automatic logic [1:0] lastSub(input logic [1:0] w);
    logic [1:0] r;
    case (w)
      `SRC_W8: r = 2'h3;
      `SRC_W16: r = 2'h1;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // Read command word, opcode leaves the pin MSB first
  function automatic logic [31:0] cmdWord();
    return {24'h000000, rev8(`READ_OPCODE)};
  endfunction

  // Next-state logic for the whole engine
  always_comb begin
    logic rxEv;
    logic rxBit;
    logic tick;
    logic wordDone;
    logic [16:0] half;
    logic [31:0] shifted;
    logic [1:0] irqSet;
    logic [1:0] irqClr;
    rxEv = 1'b0;
    rxBit = 1'b0;
    tick = 1'b0;
    wordDone = 1'b0;
    half = 17'h00000;
    shifted = st_ff.rxShift;
    irqSet = 2'h0;
    irqClr = 2'h0;
    nxt_st = st_ff;
    // Strobe-like fields default low
    nxt_st.memWe = 1'b0;
    nxt_st.rdData = 32'h00000000;
    // Pin history for edge detection
    nxt_st.sclkInPrev = serialClockIn;
    nxt_st.selPrev = deviceSelectN;

    // Software writes
    if (regWr) begin
      case (regAddr)
        `OFS_CTL: nxt_st.ctl = regWrData;
        `OFS_BAUD: nxt_st.baud = regWrData[15:0];
        `OFS_FLAG: nxt_st.flag = regWrData[15:0];
        `OFS_DMAC: nxt_st.dmac = regWrData;
        `OFS_INDEX: nxt_st.index = regWrData;
        `OFS_STEP: nxt_st.step = regWrData;
        `OFS_COUNT: nxt_st.count = regWrData;
        `OFS_IRQ_STAT: irqClr = regWrData[1:0];
        `OFS_IRQ_MASK: nxt_st.irqMask = regWrData[1:0];
        `OFS_SRC_WIDTH: nxt_st.srcWidth = regWrData[1:0];
        default: begin
          // Unmapped or read-only offset, write ignored
        end
      endcase
    end

    // Software reads, data shows one cycle later
    if (regRd) begin
      case (regAddr)
        `OFS_CTL: nxt_st.rdData = st_ff.ctl;
        `OFS_BAUD: nxt_st.rdData = {16'h0000, st_ff.baud};
        `OFS_FLAG: nxt_st.rdData = {16'h0000, st_ff.flag};
        `OFS_DMAC: nxt_st.rdData = st_ff.dmac;
        `OFS_INDEX: nxt_st.rdData = st_ff.index;
        `OFS_STEP: nxt_st.rdData = st_ff.step;
        `OFS_COUNT: nxt_st.rdData = st_ff.count;
        `OFS_IRQ_STAT: nxt_st.rdData = {30'h00000000, st_ff.irqStat};
        `OFS_IRQ_MASK: nxt_st.rdData = {30'h00000000, st_ff.irqMask};
        `OFS_SRC_WIDTH: nxt_st.rdData = {30'h00000000, st_ff.srcWidth};
        `OFS_ENGINE: nxt_st.rdData = {27'h0000000, st_ff.fsm, st_ff.mode};
        default: nxt_st.rdData = 32'h00000000;
      endcase
    end

    // Half period of the generated clock in core cycles
    half = (st_ff.baud == 16'h0000) ? 17'h00002 : {st_ff.baud, 1'b0};

    // Boot sequence
    case (st_ff.fsm)
      // First cycle after reset: catch the strap pins
      ST_INIT: begin
        nxt_st.mode = boot_config_pins;
        case (boot_config_pins)
          `BOOT_SLAVE: begin
            nxt_st.ctl = `CTL_SLAVE_RST;
            nxt_st.discard = 1'b0;
            nxt_st.fsm = ST_SLV_ARM;
          end
          `BOOT_MASTER: begin
            nxt_st.ctl = `CTL_MASTER_RST;
            nxt_st.baud = `BAUD_RST;
            nxt_st.flag = `FLAG_RST;
            nxt_st.txShift = cmdWord();
            nxt_st.discard = 1'b1;
            nxt_st.divCnt = 17'h00000;
            nxt_st.fsm = ST_MST_RUN;
          end
          default: begin
            // Parallel or internal boot: engine stays out of the way
            nxt_st.ctl = `CTL_IDLE_RST;
            nxt_st.fsm = ST_IDLE;
          end
        endcase
      end
      // Slave boot waits for a real falling edge of the select
      ST_SLV_ARM: begin
        if (st_ff.selPrev && !deviceSelectN) begin
          nxt_st.fsm = ST_SLV_RUN;
        end
      end
      // Slave boot samples on the rising host clock edge
      ST_SLV_RUN: begin
        if (st_ff.ctl[`CTL_EN] && !deviceSelectN &&
            serialClockIn && !st_ff.sclkInPrev) begin
          rxEv = 1'b1;
          rxBit = serialDataIn;
        end
      end
      // Master boot drives clock, select and the command word
      ST_MST_RUN: begin
        nxt_st.flagZeroN = st_ff.flag[`FLAG_SEL_EN] ?
                           st_ff.flag[`FLAG_SEL_VAL] : 1'b1;
        if (st_ff.ctl[`CTL_EN]) begin
          // Divider gives one enable per half period
          if (st_ff.divCnt >= half - 17'h00001) begin
            nxt_st.divCnt = 17'h00000;
            tick = 1'b1;
          end else begin
            nxt_st.divCnt = st_ff.divCnt + 17'h00001;
          end
          if (tick) begin
            if (st_ff.sclkOut) begin
              // Falling edge: put the next bit out, LSB first
              nxt_st.sclkOut = 1'b0;
              nxt_st.dataOut = st_ff.txShift[0];
              // Zeros or the same word again once the command is out
              nxt_st.txShift = {st_ff.ctl[`CTL_SEND_ZEROS_BIT] ? 1'b0 :
                                st_ff.txShift[0], st_ff.txShift[31:1]};
            end else begin
              // Rising edge: sample the slave
              nxt_st.sclkOut = 1'b1;
              rxEv = 1'b1;
              rxBit = serialDataIn;
            end
          end
        end
      end
      // Load finished or engine unused
      ST_DONE, ST_IDLE: begin
        nxt_st.divCnt = 17'h00000;
      end
      default: begin
        nxt_st.fsm = ST_IDLE;
      end
    endcase

    // Shift in LSB first; source words pack low word first
    if (rxEv) begin
      shifted = {rxBit, st_ff.rxShift[31:1]};
      nxt_st.rxShift = shifted;
      if (st_ff.subBit == lastBit(st_ff.srcWidth)) begin
        nxt_st.subBit = 5'h00;
        if (st_ff.subCnt == lastSub(st_ff.srcWidth)) begin
          nxt_st.subCnt = 2'h0;
          wordDone = 1'b1;
        end else begin
          nxt_st.subCnt = st_ff.subCnt + 2'h1;
        end
      end else begin
        nxt_st.subBit = st_ff.subBit + 5'h01;
      end
    end

    // Full shifter word: drop it or hand it to memory
    if (wordDone) begin
      if (st_ff.discard) begin
        // Word caught during the command, boot data follows
        nxt_st.discard = 1'b0;
      end else if (st_ff.ctl[`CTL_RCV] && st_ff.dmac[`DMAC_EN] &&
                   st_ff.count != 32'h00000000) begin
        nxt_st.memWe = 1'b1;
        nxt_st.memAddr = st_ff.index;
        nxt_st.memData = shifted;
        nxt_st.index = st_ff.index + st_ff.step;
        nxt_st.count = st_ff.count - 32'h00000001;
        irqSet[`IRQ_WORD] = 1'b1;
        // Last transfer ends the boot and frees the link
        if (st_ff.count == 32'h00000001) begin
          nxt_st.fsm = ST_DONE;
          nxt_st.dmac[`DMAC_EN] = 1'b0;
          nxt_st.sclkOut = 1'b1;
          nxt_st.flag[`FLAG_SEL_VAL] = 1'b1;
          nxt_st.flagZeroN = 1'b1;
          irqSet[`IRQ_DONE] = st_ff.dmac[`DMAC_INT];
        end
      end
    end

    // Sticky status: a new event beats a clear in the same cycle
    nxt_st.irqStat = (st_ff.irqStat & ~irqClr) | irqSet;
    nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqMask);
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff.fsm <= ST_INIT;
      st_ff.mode <= 2'h0;
      st_ff.ctl <= `CTL_IDLE_RST;
      st_ff.baud <= `BAUD_RST;
      st_ff.flag <= `FLAG_RST;
      st_ff.dmac <= `DMAC_RST;
      st_ff.index <= `INDEX_RST;
      st_ff.step <= `STEP_RST;
      st_ff.count <= `COUNT_RST;
      st_ff.irqStat <= 2'h0;
      st_ff.irqMask <= `IRQ_MASK_RST;
      st_ff.srcWidth <= `SRC_WIDTH_RST;
      st_ff.rxShift <= 32'h00000000;
      st_ff.txShift <= 32'h00000000;
      st_ff.subBit <= 5'h00;
      st_ff.subCnt <= 2'h0;
      st_ff.discard <= 1'b0;
      st_ff.sclkInPrev <= 1'b1;
      st_ff.selPrev <= 1'b0;
      st_ff.divCnt <= 17'h00000;
      st_ff.sclkOut <= 1'b1;
      st_ff.dataOut <= 1'b0;
      st_ff.flagZeroN <= 1'b1;
      st_ff.memWe <= 1'b0;
      st_ff.memAddr <= 32'h00000000;
      st_ff.memData <= 32'h00000000;
      st_ff.irq <= 1'b0;
      st_ff.rdData <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign regRdData = st_ff.rdData;
  assign serialClockOut = st_ff.sclkOut;
  // Clock pin driven only by a master boot
  assign serialClockOeN = ~st_ff.ctl[`CTL_MS];
  assign serialDataOut = st_ff.dataOut;
  // Slave boot keeps its output line off
  assign serialDataOeN = st_ff.ctl[`CTL_INPUT_LINE_DISABLE_BIT] | (st_ff.ctl == `CTL_IDLE_RST);
  assign generalFlagZeroN = st_ff.flagZeroN;
  assign memWe = st_ff.memWe;
  assign memAddr = st_ff.memAddr;
  assign memData = st_ff.memData;
  assign bootDone = (st_ff.fsm == ST_DONE);
  assign irq = st_ff.irq;

endmodule
`default_nettype wire

// ===== shared/spi_boot_regs.svh
// Offsets, field positions, reset values and codes of the serial boot loader
`ifndef SPI_BOOT_REGS_SVH
`define SPI_BOOT_REGS_SVH

// Register byte offsets
`define OFS_CTL 8'h00
`define OFS_BAUD 8'h04
`define OFS_FLAG 8'h08
`define OFS_DMAC 8'h0c
`define OFS_INDEX 8'h10
`define OFS_STEP 8'h14
`define OFS_COUNT 8'h18
`define OFS_IRQ_STAT 8'h1c
`define OFS_IRQ_MASK 8'h20
`define OFS_SRC_WIDTH 8'h24
`define OFS_ENGINE 8'h28

// Reset values
`define CTL_IDLE_RST 32'h00000000
`define CTL_SLAVE_RST 32'h00004d22
`define CTL_MASTER_RST 32'h00005d06
`define BAUD_RST 16'h0064
`define FLAG_RST 16'hfe01
`define DMAC_RST 32'h00000007
`define INDEX_RST 32'h00080000
`define STEP_RST 32'h00000001
`define COUNT_RST 32'h00000180
`define IRQ_MASK_RST 2'h1
`define SRC_WIDTH_RST 2'h2

// Control field positions
`define CTL_RCV 1
`define CTL_SEND_ZEROS_BIT 2
`define CTL_INPUT_LINE_DISABLE_BIT 5
`define CTL_WL_LO 7
`define CTL_WL_HI 8
`define CTL_BIT_ORDER_BIT 9
`define CTL_CLOCK_PHASE_BIT 10
`define CTL_CLOCK_POLARITY_BIT 11
`define CTL_MS 12
`define CTL_EN 14

// DMA control, flag and interrupt field positions
`define DMAC_EN 0
`define DMAC_RX 1
`define DMAC_INT 2
`define FLAG_SEL_EN 0
`define FLAG_SEL_VAL 8
`define IRQ_DONE 0
`define IRQ_WORD 1

// Boot pin codes, source widths and command opcode
`define BOOT_SLAVE 2'h0
`define BOOT_MASTER 2'h1
`define SRC_W8 2'h0
`define SRC_W16 2'h1
`define READ_OPCODE 8'h03

`endif

// ===== shared/spi_boot_pkg.sv
// Types of the serial boot loader engine
package spi_boot_pkg;

  // Engine sequence
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_SLV_ARM = 3'b001,
    ST_SLV_RUN = 3'b010,
    ST_MST_RUN = 3'b011,
    ST_DONE = 3'b100,
    ST_IDLE = 3'b101
  } boot_state_t;

  // Complete engine state
  typedef struct packed {
    boot_state_t fsm;
    logic [1:0] mode;
    logic [31:0] ctl;
    logic [15:0] baud;
    logic [15:0] flag;
    logic [31:0] dmac;
    logic [31:0] index;
    logic [31:0] step;
    logic [31:0] count;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic [1:0] srcWidth;
    logic [31:0] rxShift;
    logic [31:0] txShift;
    logic [4:0] subBit;
    logic [1:0] subCnt;
    logic discard;
    logic sclkInPrev;
    logic selPrev;
    logic [16:0] divCnt;
    logic sclkOut;
    logic dataOut;
    logic flagZeroN;
    logic memWe;
    logic [31:0] memAddr;
    logic [31:0] memData;
    logic irq;
    logic [31:0] rdData;
  } engine_state_t;

endpackage

// ===== testbench/spi_boot_loader_engine_properties.sv
// Port checker of the serial boot loader engine
`timescale 1ns/1ps
`default_nettype none
module spi_boot_loader_engine_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial side
  input wire logic serialClockOut,
  input wire logic serialClockOeN,
  input wire logic serialDataOut,
  input wire logic serialDataOeN,
  input wire logic generalFlagZeroN,
  // Memory side and status
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic bootDone
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic clkPrev_ff; // Clock level one cycle back
  logic [6:0] riseCnt_ff; // Clock rises within the frame
  logic [31:0] lastAddr_ff; // Address of the previous store
  logic stored_ff; // A store has been seen
  // Count frame rises and remember the last store
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clkPrev_ff <= 1'b1;
      riseCnt_ff <= 7'h00;
      lastAddr_ff <= 32'h0;
      stored_ff <= 1'b0;
    end else begin
      clkPrev_ff <= serialClockOut;
      if (generalFlagZeroN) begin
        riseCnt_ff <= 7'h00;
      end else if (serialClockOut && !clkPrev_ff && riseCnt_ff != 7'h7f) begin
        riseCnt_ff <= riseCnt_ff + 7'h01;
      end
      if (memWe) begin
        stored_ff <= 1'b1;
        lastAddr_ff <= memAddr;
      end
    end
  end
  cmd_bits_a: assert property (
    serialClockOut && !clkPrev_ff && !generalFlagZeroN && riseCnt_ff < 7'd32
    |-> serialDataOut == (riseCnt_ff == 7'd6 || riseCnt_ff == 7'd7))
    else $error("read command bit wrong");
  discard_a: assert property (
    memWe && !generalFlagZeroN |-> riseCnt_ff >= 7'd63)
    else $error("store before command word was discarded");
  store_addr_a: assert property (
    memWe |-> memAddr == (stored_ff ? lastAddr_ff + 32'h1 : 32'h00080000))
    else $error("store address wrong");
  store_pulse_a: assert property (
    memWe |=> !memWe)
    else $error("store strobe longer than one cycle");
  flag_clock_a: assert property (
    generalFlagZeroN |-> serialClockOut)
    else $error("clock moves outside a frame");
  master_drive_a: assert property (
    !generalFlagZeroN |-> !serialClockOeN && !serialDataOeN)
    else $error("master frame without driven pins");
  data_off_a: assert property (
    serialClockOeN |-> serialDataOeN)
    else $error("data output enabled in slave role");
  done_hold_a: assert property (
    bootDone |=> bootDone && generalFlagZeroN && serialClockOut)
    else $error("completion not held or select not released");
endmodule
bind spi_boot_loader_engine spi_boot_loader_engine_properties u_props (
  .core_clk(core_clk), .rst(rst), .serialClockOut(serialClockOut),
  .serialClockOeN(serialClockOeN), .serialDataOut(serialDataOut),
  .serialDataOeN(serialDataOeN), .generalFlagZeroN(generalFlagZeroN),
  .memWe(memWe), .memAddr(memAddr), .bootDone(bootDone));
`default_nettype wire

// ===== testbench/spi_flash_model.sv
// Serial flash answering the master boot read
`timescale 1ns/1ps
`default_nettype none
module spi_flash_model (
  // Serial pins
  input wire logic sclk,
  input wire logic selN,
  output logic miso
);
  logic [31:0] word = 32'ha5a5a5a5; // Word shifted during the command
  int bitIx = 0; // Bit within the word
  int wordIx = 0; // Words sent so far
  initial miso = 1'b0;
  // Next bit on each falling clock, LSB first, no gaps
  always @(negedge sclk) begin
    if (!selN) begin
      miso <= word[bitIx];
      if (bitIx == 31) begin
        wordIx++;
        word = {wordIx[15:0], ~wordIx[15:0]};
        bitIx = 0;
      end else begin
        bitIx++;
      end
    end
  end
  // Released line no longer shows the last bit
  always @(posedge selN) miso <= ~miso;
endmodule
`default_nettype wire

// ===== testbench/spi_boot_loader_engine_tb.sv
// Self-checking testbench of the serial boot loader engine
`timescale 1ns/1ps
`default_nettype none
`include "spi_boot_regs.svh"
module spi_boot_loader_engine_tb;
  logic core_clk = 1'b0; // Core clock
  logic rst = 1'b1; // Reset
  logic [1:0] bootPins = 2'h0; // Strap pins
  logic [7:0] regAddr = 8'h00; // Register port
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic hostClk = 1'b1; // Host side of slave boot
  logic selN = 1'b1;
  logic mosi = 1'b0;
  logic clkOut, clkOeN, dataOut, dataOeN, flagN, memWe, bootDone, irq;
  logic [31:0] memAddr, memData;
  wire logic miso;
  wire logic clkPin = clkOeN ? hostClk : clkOut; // Clock pin level
  wire logic dataIn = clkOeN ? mosi : miso; // Data pin level
  int bad_count = 0;
  int check_count = 0;
  int storeCnt = 0; // Stores seen this boot
  logic [31:0] expQ[$]; // Expected store data
  logic [7:0] ofsTab [11] = '{`OFS_CTL, `OFS_BAUD, `OFS_FLAG, `OFS_DMAC,
    `OFS_INDEX, `OFS_STEP, `OFS_COUNT, `OFS_IRQ_MASK, `OFS_SRC_WIDTH,
    `OFS_ENGINE, 8'h3c};
  logic [31:0] rstTab [11] = '{32'h00004d22, 32'h64, 32'hfe01, 32'h7,
    32'h00080000, 32'h1, 32'h180, 32'h1, 32'h2, 32'h4, 32'h0};
  spi_boot_loader_engine u_spi_boot_loader_engine (
    .core_clk(core_clk), .rst(rst), .boot_config_pins(bootPins),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .serialClockIn(clkPin),
    .serialClockOut(clkOut), .serialClockOeN(clkOeN),
    .deviceSelectN(selN), .serialDataIn(dataIn), .serialDataOut(dataOut),
    .serialDataOeN(dataOeN), .generalFlagZeroN(flagN), .memWe(memWe),
    .memAddr(memAddr), .memData(memData), .bootDone(bootDone), .irq(irq));
  spi_flash_model u_spi_flash_model (.sclk(clkPin), .selN(flagN),
    .miso(miso));
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Boot stream word k
  function automatic logic [31:0] pat(input int k);
    return {k[15:0] + 16'h1, ~(k[15:0] + 16'h1)};
  endfunction
  // One write cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk) regWr <= 1'b0;
  endtask
  // One read cycle, data checked in the cycle after
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk) regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk) regRd <= 1'b0;
    @(negedge core_clk) chk(regRdData, e);
  endtask
  // Reset with the given strap
  task automatic boot(input logic [1:0] pins);
    rst <= 1'b1;
    bootPins <= pins;
    storeCnt = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  // Host sends one word LSB first, select kept low
  task automatic hostWord(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk) hostClk <= 1'b0;
      mosi <= w[i];
      repeat (2) @(posedge core_clk);
      hostClk <= 1'b1;
      repeat (2) @(posedge core_clk);
    end
  endtask
  // Every store checked against the stream
  always @(negedge core_clk) begin
    if (memWe === 1'b1) begin
      chk(memAddr, 32'h00080000 + 32'(storeCnt));
      chk(memData, expQ.size() != 0 ? expQ.pop_front() : 32'h0);
      storeCnt++;
    end
  end
  // Verdict
  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end
  // Slave boot, then master boot
  initial begin
    boot(2'h0);
    for (int i = 0; i < 11; i++) rd(ofsTab[i], rstTab[i]);
    wr(`OFS_COUNT, 32'h4);
    wr(`OFS_SRC_WIDTH, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h3);
    @(posedge core_clk) selN <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      expQ.push_back(pat(k));
      hostWord(pat(k));
    end
    hostWord(32'h5a5a5a5a);
    chk(32'(storeCnt), 32'h4);
    chk({30'h0, bootDone, irq}, 32'h3);
    rd(`OFS_IRQ_STAT, 32'h3);
    wr(`OFS_IRQ_MASK, 32'h0);
    repeat (2) @(negedge core_clk);
    chk(32'(irq), 32'h0);
    wr(`OFS_IRQ_STAT, 32'h3);
    wr(`OFS_IRQ_MASK, 32'h3);
    repeat (2) @(negedge core_clk);
    chk(32'(irq), 32'h0);
    boot(2'h1);
    rd(`OFS_CTL, 32'h00005d06);
    wr(`OFS_BAUD, 32'h1);
    wr(`OFS_SRC_WIDTH, 32'h1);
    for (int k = 0; k < 384; k++) expQ.push_back(pat(k));
    for (int i = 0; i < 60000 && bootDone !== 1'b1; i++) @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(storeCnt), 32'd384);
    chk({30'h0, flagN, irq}, 32'h3);
    rd(`OFS_COUNT, 32'h0);
    boot(2'h2);
    rd(`OFS_ENGINE, 32'h00000016);
    rd(`OFS_CTL, 32'h00000000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
